// ---- hdl/flash_seq_pkg.sv ----
// Constants and types for the flash self-programming sequencer.
// Assumes a single system clock; no software-visible bus.
package flash_seq_pkg;
    localparam int ROW_INSTR       = 64;
    localparam int ROW_BYTES       = 192;
    localparam int PAGE_ROWS       = 8;
    localparam int PAGE_INSTR      = 512;
    localparam int PAGE_BYTES      = 1536;
    localparam int IDX_W           = 6;
    localparam int WORD_W          = 24;
    localparam int ADDR_W          = 24;
    localparam int START_BIT       = 15;
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [1:0] OP_WORD  = 2'h0;
    localparam logic [1:0] OP_ROW   = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h2;
    localparam int TBLWR_CYCLES    = 2;
    localparam int ROW_TIME_NS     = 1473000;
    localparam int WORD_TIME_NS    = 50000;
    localparam int ERASE_TIME_NS   = 20000000;
    localparam int CLK_PERIOD_NS   = 8;
    localparam int ROW_CYCLES      = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WORD_CYCLES     = (WORD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES    = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_ARMED} key_state_t;
    typedef enum logic [2:0] {SEQ_IDLE, SEQ_BUSY, SEQ_ROWWR, SEQ_DONE} seq_state_t;
endpackage

// ---- hdl/hold_buf_mem.sv ----
// Holding buffer memory: one row of instruction words, registered read.
// Assumes writes and reads on the same clock.
`timescale 1ns/10ps
module hold_buf_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6,
    parameter int DW    = 24,
    parameter int LW    = 16
) (
    input  wire logic          ref_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic          wr_hi,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];
    // Low write fills the whole low word, high write only the upper byte
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            if (wr_hi) begin
                mem[wr_addr][DW-1:LW] <= wr_data[DW-1:LW];
            end else begin
                mem[wr_addr][LW-1:0] <= wr_data[LW-1:0];
            end
        end
        rd_data <= mem[rd_addr];
    end
endmodule // hold_buf_mem

// ---- hdl/flash_self_program_seq.sv ----
// Flash self-programming sequencer: holding buffer, unlock key, timed operations.
// Assumes the core stalls on cpu_stall and the flash macro takes row data per cycle.
// Overview of operation
// - Flash is organised as rows of 64 instructions, 192 bytes each.
// - Erase works only on pages of eight rows, 512 instructions.
// - Programming covers either a whole row or a single word.
// - Pages align to 1536 bytes and rows to 192 bytes from program memory start.
// - A holding buffer keeps 64 instructions of write data ahead of the array.
// - Each table write is a buffer-only write completing in two cycles.
// - Each row needs its own programming cycle; none spans two rows.
// - Setting control bit 15 starts the operation and hardware clears it at the end.
// - The core is stalled while an operation runs.
`timescale 1ns/10ps
module flash_self_program_seq #(
    parameter int ROW_CYC   = flash_seq_pkg::ROW_CYCLES,
    parameter int WORD_CYC  = flash_seq_pkg::WORD_CYCLES,
    parameter int ERASE_CYC = flash_seq_pkg::ERASE_CYCLES
) (
    input  wire logic                              ref_clk,
    input  wire logic                              reset,
    input  wire logic                              tbl_wr,
    input  wire logic                              tbl_hi,
    input  wire logic [flash_seq_pkg::ADDR_W-1:0]  tbl_addr,
    input  wire logic [15:0]                       tbl_data,
    input  wire logic                              key_wr,
    input  wire logic [7:0]                        key_data,
    input  wire logic                              ctrl_wr,
    input  wire logic [15:0]                       ctrl_data,
    input  wire logic                              other_wr,
    output logic                                   tbl_done,
    output logic [15:0]                            ctrl_rd,
    output logic                                   cpu_stall,
    output logic                                   fl_prog,
    output logic                                   fl_erase,
    output logic [flash_seq_pkg::ADDR_W-1:0]       fl_addr,
    output logic [flash_seq_pkg::WORD_W-1:0]       fl_data
);
    localparam int CW = 32;

    function automatic logic [flash_seq_pkg::ADDR_W-1:0] align_down(
        input logic [flash_seq_pkg::ADDR_W-1:0] a, input int unit);
        align_down = a - flash_seq_pkg::ADDR_W'(a % unit);
    endfunction

    // Holding buffer write path, two-cycle acknowledge
    logic tbl_ph_q, tbl_ph_d;
    logic [flash_seq_pkg::IDX_W-1:0] wr_idx;
    logic [flash_seq_pkg::IDX_W-1:0] rd_idx_q, rd_idx_d;
    logic [flash_seq_pkg::WORD_W-1:0] buf_rd;
    logic [flash_seq_pkg::WORD_W-1:0] wdata;
    // Instruction index: program addresses step by two per instruction
    assign wr_idx = flash_seq_pkg::IDX_W'(tbl_addr >> 1);
    assign wdata  = {tbl_data[7:0], tbl_data};

    hold_buf_mem #(
        .DEPTH (flash_seq_pkg::ROW_INSTR),
        .AW    (flash_seq_pkg::IDX_W),
        .DW    (flash_seq_pkg::WORD_W)
    ) hold_buf_mem_inst (
        .ref_clk  (ref_clk),
        .wr_en    (tbl_wr && !cpu_stall),
        .wr_addr  (wr_idx),
        .wr_data  (wdata),
        .wr_hi    (tbl_hi),
        .rd_addr  (rd_idx_d),
        .rd_data  (buf_rd)
    );

    always_comb begin
        tbl_ph_d = 1'b0;
        if (tbl_wr && !tbl_ph_q && !cpu_stall) begin
            tbl_ph_d = 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tbl_ph_q <= 1'b0;
        end else begin
            tbl_ph_q <= tbl_ph_d;
        end
    end
    assign tbl_done = tbl_ph_q;

    // Unlock key detector
    flash_seq_pkg::key_state_t key_q, key_d;
    always_comb begin
        key_d = key_q;
        case (key_q)
            flash_seq_pkg::KEY_IDLE: begin
                if (key_wr && key_data == flash_seq_pkg::KEY_FIRST) begin
                    key_d = flash_seq_pkg::KEY_GOT1;
                end
            end
            flash_seq_pkg::KEY_GOT1: begin
                if (key_wr) begin
                    key_d = (key_data == flash_seq_pkg::KEY_SECOND) ? flash_seq_pkg::KEY_ARMED
                                                                    : flash_seq_pkg::KEY_IDLE;
                end else if (tbl_wr || ctrl_wr || other_wr) begin
                    key_d = flash_seq_pkg::KEY_IDLE;
                end
            end
            flash_seq_pkg::KEY_ARMED: begin
                if (key_wr || tbl_wr || ctrl_wr || other_wr) begin
                    key_d = flash_seq_pkg::KEY_IDLE;
                end
            end
            default: key_d = flash_seq_pkg::KEY_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            key_q <= flash_seq_pkg::KEY_IDLE;
        end else begin
            key_q <= key_d;
        end
    end

    // Operation sequencer
    flash_seq_pkg::seq_state_t st_q, st_d;
    logic [1:0]  op_q, op_d;
    logic        start_q, start_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [flash_seq_pkg::ADDR_W-1:0] base_q, base_d;
    logic [flash_seq_pkg::ADDR_W-1:0] faddr_q, faddr_d;
    logic [flash_seq_pkg::WORD_W-1:0] fdata_q, fdata_d;
    logic        prog_q, prog_d, erase_q, erase_d;
    logic        launch;

    assign launch = ctrl_wr && ctrl_data[flash_seq_pkg::START_BIT]
                    && key_q == flash_seq_pkg::KEY_ARMED && st_q == flash_seq_pkg::SEQ_IDLE;

    always_comb begin
        st_d = st_q; op_d = op_q; start_d = start_q; cnt_d = cnt_q;
        base_d = base_q; rd_idx_d = rd_idx_q; faddr_d = faddr_q; fdata_d = fdata_q;
        prog_d = 1'b0; erase_d = 1'b0;
        case (st_q)
            flash_seq_pkg::SEQ_IDLE: begin
                if (ctrl_wr && !launch) begin
                    op_d = ctrl_data[1:0];
                end
                if (launch) begin
                    start_d = 1'b1;
                    op_d    = ctrl_data[1:0];
                    st_d    = flash_seq_pkg::SEQ_BUSY;
                    rd_idx_d = '0;
                    case (ctrl_data[1:0])
                        flash_seq_pkg::OP_ERASE: begin
                            base_d = align_down(tbl_addr, 2 * flash_seq_pkg::PAGE_INSTR);
                            cnt_d  = CW'(ERASE_CYC);
                        end
                        flash_seq_pkg::OP_ROW: begin
                            base_d = align_down(tbl_addr, 2 * flash_seq_pkg::ROW_INSTR);
                            cnt_d  = CW'(ROW_CYC);
                        end
                        default: begin
                            base_d   = tbl_addr;
                            rd_idx_d = wr_idx;
                            cnt_d    = CW'(WORD_CYC);
                        end
                    endcase
                end
            end
            flash_seq_pkg::SEQ_BUSY: begin
                // First pulse of each operation; a row streams the rest in the next state, which runs out the count
                faddr_d  = base_q;
                rd_idx_d = '0;
                st_d     = flash_seq_pkg::SEQ_ROWWR;
                if (op_q == flash_seq_pkg::OP_ERASE) begin
                    erase_d = 1'b1;
                end else begin
                    prog_d = 1'b1;
                    fdata_d = buf_rd;
                    if (op_q == flash_seq_pkg::OP_ROW) begin
                        rd_idx_d = rd_idx_q + 1'b1;
                    end
                end
                cnt_d = cnt_q - 1;
                if (cnt_q <= 1) begin
                    st_d = flash_seq_pkg::SEQ_DONE;
                end
            end
            flash_seq_pkg::SEQ_ROWWR: begin
                // Streams the rest of one row, then waits out the operation time
                if (rd_idx_q != '0) begin
                    prog_d  = 1'b1;
                    fdata_d = buf_rd;
                    faddr_d = faddr_q + flash_seq_pkg::ADDR_W'(2);
                    rd_idx_d = rd_idx_q + 1'b1;
                end
                cnt_d = cnt_q - 1;
                if (cnt_q <= 1) begin
                    st_d = flash_seq_pkg::SEQ_DONE;
                end
            end
            flash_seq_pkg::SEQ_DONE: begin
                start_d = 1'b0;
                st_d    = flash_seq_pkg::SEQ_IDLE;
            end
            default: st_d = flash_seq_pkg::SEQ_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= flash_seq_pkg::SEQ_IDLE;
            op_q <= flash_seq_pkg::OP_WORD;
            start_q <= 1'b0;
            cnt_q <= '0;
            base_q <= '0;
            rd_idx_q <= '0;
            faddr_q <= '0;
            fdata_q <= '0;
            prog_q <= 1'b0;
            erase_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            start_q <= start_d;
            cnt_q <= cnt_d;
            base_q <= base_d;
            rd_idx_q <= rd_idx_d;
            faddr_q <= faddr_d;
            fdata_q <= fdata_d;
            prog_q <= prog_d;
            erase_q <= erase_d;
        end
    end

    assign cpu_stall = start_q;
    assign ctrl_rd   = {start_q, 13'h0000, op_q};
    assign fl_prog   = prog_q;
    assign fl_erase  = erase_q;
    assign fl_addr   = faddr_q;
    assign fl_data   = fdata_q;

    a_start_clears: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(start_q) |-> $past(st_q) == flash_seq_pkg::SEQ_DONE) else $error("start cleared early");
    a_stall_during_op: assert property (@(posedge ref_clk) disable iff (reset)
        st_q != flash_seq_pkg::SEQ_IDLE |-> cpu_stall) else $error("core not stalled");
    a_key_gates_start: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(start_q) |-> $past(key_q) == flash_seq_pkg::KEY_ARMED) else $error("start without key");
    a_tbl_two_cycle: assert property (@(posedge ref_clk) disable iff (reset)
        tbl_wr && !tbl_ph_q && !cpu_stall |=> tbl_done) else $error("table write ack late");
    a_erase_aligned: assert property (@(posedge ref_clk) disable iff (reset)
        fl_erase |-> fl_addr % (2 * flash_seq_pkg::PAGE_INSTR) == 0) else $error("erase misaligned");
    a_row_single: assert property (@(posedge ref_clk) disable iff (reset)
        fl_prog && op_q == flash_seq_pkg::OP_ROW |-> fl_addr - base_q < 2 * flash_seq_pkg::ROW_INSTR)
        else $error("row write spans rows");
    a_word_one: assert property (@(posedge ref_clk) disable iff (reset)
        fl_prog && op_q == flash_seq_pkg::OP_WORD |=> !fl_prog) else $error("word write repeated");
    a_erase_noprog: assert property (@(posedge ref_clk) disable iff (reset)
        fl_erase |-> !fl_prog) else $error("erase with program");
endmodule // flash_self_program_seq

// ---- tb/core_model.sv ----
// Behavioural processor core: table writes, unlock key and control writes.
// Assumes the sequencer samples every strobe on the rising edge of ref_clk.
`timescale 1ns/10ps
module core_model (
    input  wire logic                             ref_clk,
    input  wire logic                             tbl_done,
    input  wire logic                             cpu_stall,
    output logic                                  tbl_wr,
    output logic                                  tbl_hi,
    output logic [flash_seq_pkg::ADDR_W-1:0]      tbl_addr,
    output logic [15:0]                           tbl_data,
    output logic                                  key_wr,
    output logic [7:0]                            key_data,
    output logic                                  ctrl_wr,
    output logic [15:0]                           ctrl_data,
    output logic                                  other_wr
);
    initial begin
        {tbl_wr, tbl_hi, key_wr, ctrl_wr, other_wr} = 5'h00;
        tbl_addr = 24'h000000;
        tbl_data = 16'h0000;
        key_data = 8'h00;
        ctrl_data = 16'h0000;
    end

    // One table write held until acknowledged; returns the cycles it took
    task automatic tbl_write(input logic hi, input logic [23:0] addr, input logic [15:0] data, output int cyc);
        cyc = 0;
        @(posedge ref_clk);
        #1;
        tbl_wr = 1'b1;
        tbl_hi = hi;
        tbl_addr = addr;
        tbl_data = data;
        do begin
            @(posedge ref_clk);
            cyc++;
        end while (tbl_done !== 1'b1 && cyc < 16);
        #1;
        tbl_wr = 1'b0;
        tbl_data = ~data;
    endtask

    // Fills n slots in order from the given base address, low word then high byte
    task automatic fill(input logic [23:0] base, input int n, output int cyc);
        int c;
        for (int i = 0; i < n; i++) begin
            tbl_write(1'b0, base + 24'(2 * i), 16'hA000 + 16'(i), c);
            if (i == 0)
                cyc = c;
            tbl_write(1'b1, base + 24'(2 * i), 16'h0030 + 16'(i), c);
        end
    endtask

    // Key pair then start; spoil 1 slips another write between the keys, 2 skips them
    task automatic start_op(input logic [1:0] op, input int spoil);
        @(posedge ref_clk);
        #1;
        if (spoil != 2) begin
            key_wr = 1'b1;
            key_data = flash_seq_pkg::KEY_FIRST;
            @(posedge ref_clk);
            #1;
            if (spoil == 1) begin
                key_wr = 1'b0;
                other_wr = 1'b1;
                @(posedge ref_clk);
                #1;
                other_wr = 1'b0;
                key_wr = 1'b1;
            end
            key_data = flash_seq_pkg::KEY_SECOND;
            @(posedge ref_clk);
            #1;
            key_wr = 1'b0;
            key_data = ~key_data;
        end
        ctrl_wr = 1'b1;
        ctrl_data = {14'h0000, op};
        ctrl_data[flash_seq_pkg::START_BIT] = 1'b1;
        @(posedge ref_clk);
        #1;
        ctrl_wr = 1'b0;
        ctrl_data = ~ctrl_data;
    endtask
endmodule // core_model

// ---- tb/tb_flash_self_program_seq.sv ----
// Self-checking bench for the flash self-programming sequencer.
// Assumes shortened operation times set through the sequencer's parameters.
`timescale 1ns/10ps
module tb_flash_self_program_seq;
    localparam int ROW_N   = 100;
    localparam int WORD_N  = 20;
    localparam int ERASE_N = 150;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        tbl_wr, tbl_hi, key_wr, ctrl_wr, other_wr, tbl_done, cpu_stall, fl_prog, fl_erase, cap_erase;
    logic [23:0] tbl_addr, fl_addr, fl_data, cap_addr, cap_data, last_addr, last_data;
    logic [15:0] tbl_data, ctrl_data, ctrl_rd;
    logic [7:0]  key_data;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          npulse = 0;
    int          cycles = 0;

    always #4 ref_clk = ~ref_clk;

    flash_self_program_seq #(.ROW_CYC(ROW_N), .WORD_CYC(WORD_N), .ERASE_CYC(ERASE_N)) flash_self_program_seq_inst (
        .ref_clk(ref_clk), .reset(reset), .tbl_wr(tbl_wr), .tbl_hi(tbl_hi), .tbl_addr(tbl_addr),
        .tbl_data(tbl_data), .key_wr(key_wr), .key_data(key_data), .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data),
        .other_wr(other_wr), .tbl_done(tbl_done), .ctrl_rd(ctrl_rd), .cpu_stall(cpu_stall),
        .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_addr(fl_addr), .fl_data(fl_data));
    core_model core_model_inst (
        .ref_clk(ref_clk), .tbl_done(tbl_done), .cpu_stall(cpu_stall), .tbl_wr(tbl_wr), .tbl_hi(tbl_hi),
        .tbl_addr(tbl_addr), .tbl_data(tbl_data), .key_wr(key_wr), .key_data(key_data), .ctrl_wr(ctrl_wr),
        .ctrl_data(ctrl_data), .other_wr(other_wr));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Timeout, and capture of the first flash pulse of each operation
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            finish_test();
        end
        if (fl_prog === 1'b1 || fl_erase === 1'b1) begin
            if (npulse == 0) begin
                cap_addr = fl_addr;
                cap_data = fl_data;
                cap_erase = fl_erase;
            end
            last_addr = fl_addr;
            last_data = fl_data;
            npulse++;
        end
    end

    task automatic run_op(input logic [1:0] op, input int cyc, input int pulses, input logic [23:0] addr,
                          input logic [23:0] data);
        int n;
        npulse = 0;
        core_model_inst.start_op(op, 0);
        n = 0;
        while (cpu_stall !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cmp({31'h0, cpu_stall}, 32'h1);
        cmp({31'h0, ctrl_rd[flash_seq_pkg::START_BIT]}, 32'h1);
        cmp({30'h0, ctrl_rd[1:0]}, {30'h0, op});
        n = 0;
        while (cpu_stall === 1'b1 && n < cyc + 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cmp(32'(n), 32'(cyc + 1));
        cmp({31'h0, ctrl_rd[flash_seq_pkg::START_BIT]}, 32'h0);
        cmp(32'(npulse), 32'(pulses));
        cmp({8'h00, cap_addr}, {8'h00, addr});
        cmp({31'h0, cap_erase}, 32'(op == flash_seq_pkg::OP_ERASE));
        if (op != flash_seq_pkg::OP_ERASE)
            cmp({8'h00, cap_data}, {8'h00, data});
    endtask

    task automatic check_row_program();
        int c;
        core_model_inst.fill(24'h000180, 64, c);
        cmp(32'(c), 32'(flash_seq_pkg::TBLWR_CYCLES));
        run_op(flash_seq_pkg::OP_ROW, ROW_N, 64, 24'h000180, 24'h30A000);
        cmp({8'h00, last_addr}, 32'h000001FE);
        cmp({8'h00, last_data}, 32'h006FA03F);
    endtask

    task automatic check_refused_start();
        for (int s = 1; s <= 2; s++) begin
            npulse = 0;
            core_model_inst.start_op(flash_seq_pkg::OP_ROW, s);
            repeat (4) @(posedge ref_clk);
            #1;
            cmp({31'h0, cpu_stall}, 32'h0);
            cmp({31'h0, ctrl_rd[flash_seq_pkg::START_BIT]}, 32'h0);
            cmp(32'(npulse), 32'h0);
        end
    endtask

    task automatic check_word_program();
        int c;
        core_model_inst.fill(24'h000206, 1, c);
        run_op(flash_seq_pkg::OP_WORD, WORD_N, 1, 24'h000206, 24'h30A000);
    endtask

    task automatic check_page_erase();
        int c;
        core_model_inst.fill(24'h0004C2, 1, c);
        run_op(flash_seq_pkg::OP_ERASE, ERASE_N, 1, 24'h000400, 24'h000000);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        check_row_program();
        check_refused_start();
        check_word_program();
        check_page_erase();
        finish_test();
    end
endmodule // tb_flash_self_program_seq
